// File: rtl/fns_pkg.sv
// ****************************************************************
// Purpose: constants for the negate / scale / reciprocal seed slice
// Assumes: single extended operands, 44 bits: sign, 11 exp, 32 frac
// Notes:   opcode patterns, status bit slots and timing counts
// ****************************************************************
package fns_pkg;

  // ****************************************************************
  // operand format
  // ****************************************************************
  localparam int                 SEP_W        = 44;  // register width
  localparam int                 SEP_FRAC_W   = 32;  // fraction bits
  localparam int                 SCALE_W      = 11;  // scale factor
  localparam int                 HI_LSB       = 32;  // high portion lsb
  localparam logic [10:0]        SEP_EXP_ONES = 11'h7FF;
  localparam logic signed [13:0] SEP_BIAS     = 14'sd1023;
  localparam logic signed [13:0] SEP_EMIN     = -14'sd1022;
  localparam logic signed [13:0] SEP_EMAX     = 14'sd1023;
  localparam logic signed [13:0] SP_EMIN      = -14'sd126;
  localparam logic signed [13:0] SP_EMAX      = 14'sd127;
  localparam logic signed [13:0] SHIFT_CAP    = 14'sd40;
  // biased exponent of an sp subnormal whose value is q * 2^-149
  localparam logic [10:0]        SP_SUB_BEXP  = 11'd906;
  localparam logic [43:0]        QNAN_VAL     = 44'h7FF_8000_0000;

  // ****************************************************************
  // decode patterns (low 14 bits, or the whole word)
  // ****************************************************************
  localparam logic [13:0] NEG_MASK   = 14'h3F38;
  localparam logic [13:0] NEG_VAL    = 14'h2100;
  localparam logic [13:0] SCR_MASK   = 14'h3830;
  localparam logic [13:0] SCR_VAL    = 14'h1020;
  localparam logic [31:0] SCI_MASK   = 32'hFFFF_F000;
  localparam logic [31:0] SCI_VAL    = 32'h0000_B000;
  localparam logic [31:0] SEED_MASK  = 32'hFFFF_F8F8;
  localparam logic [31:0] SEED_VAL   = 32'h0000_80F8;
  localparam int          PREC_BIT   = 3;   // register scale precision
  localparam int          IPREC_BIT  = 11;  // immediate precision

  // ****************************************************************
  // status bit slots
  // ****************************************************************
  localparam int ST_INX   = 0;
  localparam int ST_DZ    = 1;
  localparam int ST_UNF   = 2;
  localparam int ST_OVF   = 3;
  localparam int ST_INVALID_OPERATION_FLAG = 4;
  localparam int ST_SIGNALLING_OPERAND_FLAG  = 5;
  localparam int ST_NAN   = 6;
  localparam int ST_UNORDERED_COMPARE_FLAG  = 7;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [4:0] BASE_CYCLES = 5'd2;  // oscillator cycles

  typedef enum logic [1:0] {
    OP_NEG   = 2'b00,
    OP_SCALE = 2'b01,
    OP_SEED  = 2'b10
  } fns_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } fns_state_t;

endpackage

// File: rtl/fns_unit.sv
// Purpose: negate, power-of-two scale and reciprocal seed datapath
// Assumes: controller issues decoded words with mv + da wait count
// Notes:   rounding is to nearest even; seed table is computed
`timescale 1ns/1ps

module fns_unit
  import fns_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              instr_valid,   // decoded word offered
  input  wire logic [31:0]       instr_word,    // instruction word
  input  wire logic [3:0]        wait_cycles,   // mv + da cycles
  output logic                   instr_ready,   // slice idle
  input  wire logic              reg_load_en,   // controller write
  input  wire logic [2:0]        reg_load_sel,
  input  wire logic [SEP_W-1:0]  reg_load_data,
  input  wire logic [2:0]        reg_read_sel,
  output logic [SEP_W-1:0]       reg_read_data,
  output logic                   op_done,       // result written
  output logic                   cc_zero,
  output logic                   cc_negative,
  output logic                   cc_infinity,
  output logic [7:0]             exc_status,
  output logic [7:0]             exc_sticky,
  input  wire logic              sticky_clear
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [SEP_W-1:0]   data_reg_r [8];   // data alu registers
  fns_state_t         state_r;          // sequencer state
  fns_op_t            op_r;             // latched operation
  logic               sp_r;             // round to single precision
  logic [2:0]         dst_r;            // destination index
  logic [SEP_W-1:0]   dst_val_r;        // destination operand
  logic [SEP_W-1:0]   src_val_r;        // seed source operand
  logic [SCALE_W-1:0] scale_r;          // scale factor
  logic [4:0]         cnt_r;            // cycles left
  logic               done_r;
  logic               z_r;
  logic               n_r;
  logic               i_r;
  logic [7:0]         st_r;
  logic [7:0]         sticky_r;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // leading zero count of a 33-bit significand
  function automatic logic [5:0] fns_lzc33(input logic [32:0] v);
    logic found;
    begin
      fns_lzc33 = 6'd33;
      found = 1'b0;
      for (int k = 32; k >= 0; k--) begin
        if (!found && v[k]) begin
          fns_lzc33 = 6'(32 - k);
          found = 1'b1;
        end
      end
    end
  endfunction

  // round a normalized value to sp or sep and pack as sep
  // returns {ovf, unf, inx, value}
  function automatic logic [46:0] fns_round_pack(
    input logic               s,
    input logic signed [13:0] e,
    input logic [32:0]        m,
    input logic               sp
  );
    logic signed [13:0] emin;
    logic signed [13:0] emax;
    logic signed [13:0] eo;
    logic               tiny;
    logic               up;
    logic               inexact_flag;
    logic               ovf;
    logic               unf;
    logic [5:0]         sh;
    logic [5:0]         lsb;
    logic [5:0]         lz;
    logic [65:0]        wide;
    logic [65:0]        rem;
    logic [65:0]        half;
    logic [33:0]        q;
    logic [32:0]        dn;
    logic [43:0]        res;
    begin
      emin = sp ? SP_EMIN : SEP_EMIN;
      emax = sp ? SP_EMAX : SEP_EMAX;
      tiny = (e < emin);
      sh   = 6'd0;
      if (tiny) begin
        sh = ((emin - e) > SHIFT_CAP) ? 6'(SHIFT_CAP) : 6'(emin - e);
      end
      wide = {m, 33'h0} >> sh;
      lsb  = sp ? 6'd42 : 6'd33;
      q    = 34'(wide >> lsb);
      half = 66'h1 << (lsb - 6'd1);
      rem  = wide & ((66'h1 << lsb) - 66'h1);
      inexact_flag  = (rem != 66'h0);
      up   = (rem > half) || ((rem == half) && q[0]);
      q    = q + 34'(up);
      eo   = tiny ? emin : e;
      // carry out of rounding bumps the exponent
      if (sp ? q[24] : q[33]) begin
        q  = q >> 1;
        eo = eo + 14'sd1;
      end
      ovf = 1'b0;
      unf = tiny && inexact_flag;
      if (eo > emax) begin
        // too large: infinity of the same sign
        ovf = 1'b1;
        inexact_flag = 1'b1;
        res = {s, SEP_EXP_ONES, 32'h0};
      end else if (!(sp ? q[23] : q[32])) begin
        // below the target's normal range
        if (!sp) begin
          res = {s, 11'h0, q[31:0]};
        end else if (q == 34'h0) begin
          res = {s, 43'h0};
        end else begin
          lz  = fns_lzc33(q[32:0]);
          dn  = q[32:0] << lz;
          res = {s, 11'(SP_SUB_BEXP - 11'(lz)), dn[31:0]};
        end
      end else begin
        res = {s, 11'(eo + SEP_BIAS), sp ? {q[22:0], 9'h0} : q[31:0]};
      end
      return {ovf, unf, inexact_flag, res};
    end
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  logic dec_sci;
  logic dec_seed;
  logic dec_neg;
  logic dec_scr;
  logic dec_any;
  logic take;

  assign dec_sci  = ((instr_word & SCI_MASK) == SCI_VAL);
  assign dec_seed = ((instr_word & SEED_MASK) == SEED_VAL);
  assign dec_neg  = ((instr_word[13:0] & NEG_MASK) == NEG_VAL)
                    && !dec_sci && !dec_seed;
  assign dec_scr  = ((instr_word[13:0] & SCR_MASK) == SCR_VAL)
                    && !dec_sci && !dec_seed;
  assign dec_any  = dec_sci || dec_seed || dec_neg || dec_scr;
  assign instr_ready = (state_r == ST_IDLE);
  assign take     = instr_valid && instr_ready && dec_any;

  // ****************************************************************
  // operand unpack
  // ****************************************************************
  logic [SEP_W-1:0]   opnd;
  logic [10:0]        o_exp;
  logic [31:0]        o_frac;
  logic               o_zero;
  logic               o_inf;
  logic               o_nan;
  logic               o_signalling_operand_flag;
  logic [5:0]         o_lz;
  logic signed [13:0] o_e;         // unbiased exponent
  logic [32:0]        o_m;         // normalized significand

  // seed works on the source, the others on the destination
  always_comb begin
    opnd   = (op_r == OP_SEED) ? src_val_r : dst_val_r;
    o_exp  = opnd[42:32];
    o_frac = opnd[31:0];
    o_zero = (o_exp == 11'h0) && (o_frac == 32'h0);
    o_inf  = (o_exp == SEP_EXP_ONES) && (o_frac == 32'h0);
    o_nan  = (o_exp == SEP_EXP_ONES) && (o_frac != 32'h0);
    o_signalling_operand_flag = o_nan && !o_frac[31];
    o_lz   = fns_lzc33({1'b0, o_frac});
    if (o_exp == 11'h0) begin
      // denormal: shift up to a leading one
      o_m = {1'b0, o_frac} << o_lz;
      o_e = SEP_EMIN - 14'(o_lz);
    end else begin
      o_m = {1'b1, o_frac};
      o_e = 14'(o_exp) - SEP_BIAS;
    end
  end

  // ****************************************************************
  // result
  // ****************************************************************
  logic [46:0]        rp;
  logic signed [13:0] se;
  logic [32:0]        sm;
  logic [17:0]        recip;
  logic [SEP_W-1:0]   res;
  logic [7:0]         st_nxt;

  always_comb begin
    rp     = 47'h0;
    se     = 14'sd0;
    sm     = 33'h0;
    recip  = 18'h0;
    res    = opnd;
    st_nxt = 8'h0;
    case (op_r)
      OP_NEG: begin
        if (o_nan) begin
          res = {~opnd[43], opnd[42:32], 1'b1, opnd[30:0]};
        end else if (o_zero) begin
          res = 44'h0;
        end else begin
          res = {~opnd[43], opnd[42:0]};
        end
      end
      OP_SCALE: begin
        se = o_e + {{3{scale_r[10]}}, scale_r};
        rp = fns_round_pack(opnd[43], se, o_m, sp_r);
        if (o_nan) begin
          res = QNAN_VAL;
        end else if (o_zero || o_inf) begin
          res = opnd;
        end else begin
          res = rp[43:0];
          st_nxt[ST_OVF] = rp[46];
          st_nxt[ST_UNF] = rp[45];
          st_nxt[ST_INX] = rp[44];
        end
      end
      OP_SEED: begin
        recip = 18'h20000 / {9'h0, 1'b1, o_m[31:24]};
        if (o_m[31:0] == 32'h0) begin
          se = 14'sd0 - o_e;
          sm = {1'b1, 32'h0};
        end else begin
          se = 14'sd0 - o_e - 14'sd1;
          // a divisor of exactly 256 gives 512; saturate to all ones
          sm = {1'b1, (recip[9] ? 8'hFF : recip[7:0]), 24'h0};
        end
        rp = fns_round_pack(opnd[43], se, sm, 1'b0);
        if (o_nan) begin
          res = QNAN_VAL;
        end else if (o_zero) begin
          res = {opnd[43], SEP_EXP_ONES, 32'h0};
        end else if (o_inf) begin
          res = {opnd[43], 43'h0};
        end else begin
          res = rp[43:0];
          st_nxt[ST_OVF] = rp[46];
          st_nxt[ST_UNF] = rp[45];
        end
      end
      default: begin
        res = opnd;
      end
    endcase
    st_nxt[ST_SIGNALLING_OPERAND_FLAG] = o_signalling_operand_flag;
    st_nxt[ST_NAN]  = (res[42:32] == SEP_EXP_ONES)
                      && (res[31:0] != 32'h0);
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // accept a word, latch operands, count 2 + wait cycles
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r   <= ST_IDLE;
      op_r      <= OP_NEG;
      sp_r      <= 1'b0;
      dst_r     <= 3'h0;
      dst_val_r <= 44'h0;
      src_val_r <= 44'h0;
      scale_r   <= 11'h0;
      cnt_r     <= 5'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r   <= ST_EXEC;
            dst_r     <= instr_word[2:0];
            dst_val_r <= data_reg_r[instr_word[2:0]];
            src_val_r <= data_reg_r[instr_word[10:8]];
            cnt_r     <= BASE_CYCLES - 5'd1 + 5'(wait_cycles);
            if (dec_sci) begin
              op_r    <= OP_SCALE;
              sp_r    <= instr_word[IPREC_BIT];
              scale_r <= {{3{instr_word[10]}},
                          instr_word[10:3]};
            end else if (dec_scr) begin
              op_r    <= OP_SCALE;
              sp_r    <= instr_word[PREC_BIT];
              scale_r <= data_reg_r[instr_word[10:8]]
                         [HI_LSB +: SCALE_W];
            end else if (dec_seed) begin
              op_r    <= OP_SEED;
              sp_r    <= 1'b0;
            end else begin
              op_r    <= OP_NEG;
              sp_r    <= 1'b0;
            end
          end
        end
        ST_EXEC: begin
          cnt_r <= cnt_r - 5'd1;
          if (cnt_r == 5'd0) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  logic wb;
  assign wb = (state_r == ST_EXEC) && (cnt_r == 5'd0);

  // writeback beats a controller load to the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int k = 0; k < 8; k++) begin
        data_reg_r[k] <= 44'h0;
      end
    end else if (wb) begin
      data_reg_r[dst_r] <= res;
    end else if (reg_load_en) begin
      data_reg_r[reg_load_sel] <= reg_load_data;
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  // condition codes and status refresh at writeback
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      done_r <= 1'b0;
      z_r    <= 1'b0;
      n_r    <= 1'b0;
      i_r    <= 1'b0;
      st_r   <= 8'h0;
    end else begin
      done_r <= wb;
      if (wb) begin
        z_r  <= (res[42:0] == 43'h0);
        n_r  <= res[43] && !st_nxt[ST_NAN];
        i_r  <= (res[42:0] == {SEP_EXP_ONES, 32'h0});
        st_r <= st_nxt;
      end
    end
  end

  // sticky accumulation; a new event wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sticky_r <= 8'h0;
    end else begin
      sticky_r <= (sticky_clear ? 8'h0 : sticky_r)
                  | (wb ? st_nxt : 8'h0);
    end
  end

  assign reg_read_data = data_reg_r[reg_read_sel];
  assign op_done       = done_r;
  assign cc_zero       = z_r;
  assign cc_negative   = n_r;
  assign cc_infinity   = i_r;
  assign exc_status    = st_r;
  assign exc_sticky    = sticky_r;

endmodule

// File: tb/fns_unit_assertions.sv
// Purpose: port checker for the negate / scale / seed slice
// Assumes: sees only the ports of fns_unit
// Notes:   operation kind and wait count latched at acceptance
`timescale 1ns/1ps
module fns_unit_assertions
  import fns_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [3:0]  wait_cycles,
  input wire logic        instr_ready,
  input wire logic        op_done,
  input wire logic        cc_zero,
  input wire logic        cc_negative,
  input wire logic        cc_infinity,
  input wire logic [7:0]  exc_status
);
  // ********
  // helper logic
  // ********
  logic       is_seed;   // reciprocal seed word
  logic       is_scale;  // either scale form
  logic       is_neg;    // extended negate word
  logic       take;      // word accepted at this edge
  logic [1:0] kind_r;    // 0 negate, 1 scale, 2 seed
  logic [3:0] wt_r;      // wait count of the running operation
  logic [4:0] cnt_r;     // edges since acceptance
  assign is_seed  = (instr_word & SEED_MASK) == SEED_VAL;
  assign is_scale = ((instr_word & SCI_MASK) == SCI_VAL) ||
                    ((instr_word[13:0] & SCR_MASK) == SCR_VAL);
  assign is_neg   = (instr_word[13:0] & NEG_MASK) == NEG_VAL;
  assign take     = instr_valid && instr_ready &&
                    (is_seed || is_scale || is_neg);

  // latch the kind and wait count of an accepted word
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      kind_r <= 2'h0;
      wt_r   <= 4'h0;
    end else if (take) begin
      kind_r <= is_seed ? 2'h2 : (is_scale ? 2'h1 : 2'h0);
      wt_r   <= wait_cycles;
    end
  end

  // count edges from acceptance; a new take wins over done
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_r <= 5'h0;
    end else if (take) begin
      cnt_r <= 5'h1;
    end else if (op_done) begin
      cnt_r <= 5'h0;
    end else if (cnt_r != 5'h0) begin
      cnt_r <= cnt_r + 5'h1;
    end
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    instr_valid && instr_ready && (is_seed || is_scale || is_neg);
  endsequence
  sequence s_busy;
    !instr_ready && !op_done;
  endsequence

  a_take_busy:
    assert property (s_take |=> s_busy)
    else $error("ready stayed high after acceptance");
  a_done_bound:
    assert property (s_take |-> ##[3:18] op_done)
    else $error("no done pulse after acceptance");
  a_done_latency:
    assert property (op_done |-> cnt_r == {1'b0, wt_r} + 5'h3)
    else $error("done pulse at wrong cycle");
  a_done_pulse:
    assert property (op_done |=> !op_done)
    else $error("done pulse longer than one cycle");
  a_ready_back:
    assert property (op_done |-> instr_ready)
    else $error("ready low in done cycle");
  a_flags_hold:
    assert property (!op_done && $past(rstn) |->
      $stable({cc_zero, cc_negative, cc_infinity, exc_status}))
    else $error("flags changed without writeback");
  a_neg_clear:
    assert property (op_done && kind_r == 2'h0 |->
      (exc_status & 8'h9F) == 8'h00)
    else $error("negate left a status bit set");
  a_scale_clear:
    assert property (op_done && kind_r == 2'h1 |->
      (exc_status & 8'h92) == 8'h00)
    else $error("scale set a cleared status bit");
  a_seed_clear:
    assert property (op_done && kind_r == 2'h2 |->
      (exc_status & 8'h93) == 8'h00)
    else $error("seed set a cleared status bit");
  a_nan_flags:
    assert property (op_done && exc_status[ST_NAN] |->
      !cc_zero && !cc_infinity)
    else $error("nan result with zero or infinity flag");
  a_zero_inf_excl:
    assert property (op_done |-> !(cc_zero && cc_infinity))
    else $error("zero and infinity flags both set");
endmodule

bind fns_unit fns_unit_assertions u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
  .instr_word(instr_word), .wait_cycles(wait_cycles),
  .instr_ready(instr_ready), .op_done(op_done), .cc_zero(cc_zero),
  .cc_negative(cc_negative), .cc_infinity(cc_infinity),
  .exc_status(exc_status)
);

// File: tb/fns_ctrl_model.sv
// Purpose: program controller stand-in offering decoded words
// Assumes: a word is held until ready is sampled high
// Notes:   idle word lines show the inverse of the last word
`timescale 1ns/1ps
module fns_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic [31:0]      instr_word,
  output logic [3:0]       wait_cycles
);
  initial begin
    instr_valid = 1'b0;
    instr_word  = 32'h0;
    wait_cycles = 4'h0;
  end

  // offer one word after gap idle cycles; ok stays low on timeout
  task automatic issue(input logic [31:0] w, input logic [3:0] wt,
                       input int gap, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap) @(posedge sys_clk);
    if (gap > 0) #1;
    instr_valid = 1'b1;
    instr_word  = w;
    wait_cycles = wt;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge sys_clk);
      ok = instr_ready;
    end
    #1;
    instr_valid = 1'b0;
    instr_word  = ~w;
    wait_cycles = ~wt;
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the negate / scale / seed slice
// Assumes: controller model issues words, bench loads registers
// Notes:   values are sign, 11-bit exponent, 32-bit fraction
`timescale 1ns/1ps
module testbench
  import fns_pkg::*;
;
  logic             sys_clk = 1'b0;
  logic             rstn = 1'b0;
  logic             instr_valid;
  logic [31:0]      instr_word;
  logic [3:0]       wait_cycles;
  logic             instr_ready;
  logic             reg_load_en = 1'b0;
  logic [2:0]       reg_load_sel = 3'h0;
  logic [SEP_W-1:0] reg_load_data = 44'h0;
  logic [2:0]       reg_read_sel = 3'h0;
  logic [SEP_W-1:0] reg_read_data;
  logic             op_done, cc_zero, cc_negative, cc_infinity;
  logic [7:0]       exc_status, exc_sticky;
  logic             sticky_clear = 1'b0;
  int               error_cnt = 0;
  int               num_checks = 0;
  bit               ok;
  logic             seen;
  int               i;
  // seed sources, results and flags
  logic [43:0] sd_src [7] = '{44'h0, 44'h800_0000_0000,
    44'h7FF_0000_0000, 44'h7FF_0000_0001, 44'h3FF_8000_0000,
    44'h000_8000_0000, 44'h3FF_0000_0001};
  logic [43:0] sd_res [7] = '{44'h7FF_0000_0000, 44'hFFF_0000_0000,
    44'h0, 44'h7FF_8000_0000, 44'h3FE_5500_0000, 44'h7FE_0000_0000,
    44'h3FE_FF00_0000};
  logic [2:0]  sd_cc [7] = '{3'h1, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};

  always #12.5 sys_clk = ~sys_clk;

  fns_unit DUT (
    .sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .wait_cycles(wait_cycles),
    .instr_ready(instr_ready), .reg_load_en(reg_load_en),
    .reg_load_sel(reg_load_sel), .reg_load_data(reg_load_data),
    .reg_read_sel(reg_read_sel), .reg_read_data(reg_read_data),
    .op_done(op_done), .cc_zero(cc_zero), .cc_negative(cc_negative),
    .cc_infinity(cc_infinity), .exc_status(exc_status),
    .exc_sticky(exc_sticky), .sticky_clear(sticky_clear));
  fns_ctrl_model ctrl (
    .sys_clk(sys_clk), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .wait_cycles(wait_cycles));

  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [63:0] got,
                     input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // write one data register, then let an idle edge pass
  task automatic load(input logic [2:0] r, input logic [43:0] v);
    reg_load_en   = 1'b1;
    reg_load_sel  = r;
    reg_load_data = v;
    @(posedge sys_clk);
    #1;
    reg_load_en   = 1'b0;
    reg_load_data = ~v;
    @(posedge sys_clk);
    #1;
  endtask

  // issue a word, check latency, result and flags
  task automatic op(input logic [31:0] w, input logic [3:0] wt,
                    input logic [2:0] d, input logic [43:0] res,
                    input logic [2:0] cc, input logic [7:0] st);
    int n;
    ctrl.issue(w, wt, int'(wt), ok);
    chk("accept", ok, 1'b1);
    for (n = 0; n < 30 && op_done !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("latency", n, wt + 2);
    if (n == 30) wrap_up();
    reg_read_sel = d;
    #1;
    chk("result", reg_read_data, res);
    chk("cc", {cc_zero, cc_negative, cc_infinity}, cc);
    chk("status", exc_status, st);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    for (i = 0; i < 8; i++) begin
      load(i[2:0], 44'h3FF_0000_0000 | 44'(i));
      reg_read_sel = i[2:0];
      #1;
      chk("reg", reg_read_data, 44'h3FF_0000_0000 | 44'(i));
    end
    op(32'h2101, 4'h0, 3'h1, 44'hBFF_0000_0001, 3'h2, 8'h00);
    load(3'h1, 44'h7FF_0000_0000);
    op(32'hABCD_2101, 4'h3, 3'h1, 44'hFFF_0000_0000, 3'h3, 8'h00);
    load(3'h7, 44'h7FF_0000_0001);
    op(32'h2107, 4'h1, 3'h7, 44'hFFF_8000_0001, 3'h0, 8'h60);
    chk("sticky", exc_sticky[ST_SIGNALLING_OPERAND_FLAG], 1'b1);
    sticky_clear = 1'b1;
    @(posedge sys_clk);
    #1;
    sticky_clear = 1'b0;
    chk("sticky", exc_sticky, 8'h00);
    load(3'h0, 44'h0);
    op(32'h2100, 4'h0, 3'h0, 44'h0, 3'h4, 8'h00);
    load(3'h2, 44'h3FF_0000_0000);
    load(3'h3, 44'h003_0000_0000);
    op(32'h1322, 4'h2, 3'h2, 44'h402_0000_0000, 3'h0, 8'h00);
    load(3'h3, 44'h7FE_0000_0000);
    op(32'h1322, 4'h0, 3'h2, 44'h400_0000_0000, 3'h0, 8'h00);
    op(32'hBFFA, 4'h0, 3'h2, 44'h3FF_0000_0000, 3'h0, 8'h00);
    load(3'h4, 44'h3FF_0000_0001);
    op(32'hB804, 4'h0, 3'h4, 44'h3FF_0000_0000, 3'h0, 8'h01);
    load(3'h4, 44'h3FF_0000_0001);
    op(32'hB00C, 4'h0, 3'h4, 44'h400_0000_0001, 3'h0, 8'h00);
    load(3'h5, 44'h7FE_0000_0000);
    load(3'h3, 44'h001_0000_0000);
    op(32'h1325, 4'h0, 3'h5, 44'h7FF_0000_0000, 3'h1, 8'h09);
    // register form, single precision: rounds away the low bit
    load(3'h4, 44'h3FF_0000_0001);
    op(32'h132C, 4'h1, 3'h4, 44'h400_0000_0000, 3'h0, 8'h01);
    // immediate -128, single precision: tiny and inexact
    load(3'h4, 44'h3FF_0000_0001);
    op(32'hBC04, 4'h0, 3'h4, 44'h37F_0000_0000, 3'h0, 8'h05);
    for (i = 0; i < 7; i++) begin
      load(3'h6, sd_src[i]);
      op(32'h86F8, 4'h0, 3'h0, sd_res[i], sd_cc[i],
         (i == 3) ? 8'h60 : 8'h00);
    end
    // words outside the four forms are dropped without a pulse
    for (i = 0; i < 2; i++) begin
      ctrl.issue((i == 0) ? 32'h80F0 : 32'h1000_86F8, 4'h0, 0, ok);
      seen = 1'b0;
      repeat (6) begin
        @(posedge sys_clk);
        #1;
        seen = seen | op_done;
      end
      chk("dropped", seen, 1'b0);
    end
    wrap_up();
  end
endmodule
